// ==== shared/imc_regs.svh ====
// Register indices, field positions, reset values and timing counts
// for the byte-oriented I2C master. Include by bare name; no logic.
`ifndef IMC_REGS_SVH
`define IMC_REGS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IMC_CTRL_IDX 8'hE1
`define IMC_DATA_IDX 8'hE2
`define IMC_ISTAT_IDX 8'hE3
`define IMC_IMASK_IDX 8'hE4

// ------------------------------------------------------------------
// Control and status fields
// ------------------------------------------------------------------
`define IMC_F_EN 7
`define IMC_F_ACKO 6
`define IMC_F_DONE 5
`define IMC_F_ACKI 4
`define IMC_F_START 3
`define IMC_F_STOP 2
`define IMC_F_DIV_HI 1
`define IMC_F_DIV_LO 0
`define IMC_F_IRQ 0
`define IMC_CTRL_RST 8'h04
`define IMC_DATA_RST 8'h00

// ------------------------------------------------------------------
// SCL divider ratios and phases per SCL period
// ------------------------------------------------------------------
`define IMC_SCL_DIV_00 256'd4
`define IMC_SCL_DIV_01 256'd16
`define IMC_SCL_DIV_10 256'd64
`define IMC_SCL_DIV_11 256'd256
`define IMC_SCL_PHASES 256'd4
`define IMC_BIT_LAST 3'h7

`endif

// ==== shared/imc_pkg.sv ====
// Types shared by the I2C master modules.
// Assumes nothing of its surroundings.
package imc_pkg;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_bit,
    st_ack,
    st_wait,
    st_stop
  } imc_state_t;

endpackage

// ==== shared/imc_tick_if.sv ====
// Link between the byte engine and its SCL phase divider.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
interface imc_tick_if;
  logic [1:0] sel;
  logic run;
  logic tick;

  modport gen (input sel, input run, output tick);
  modport eng (output sel, output run, input tick);
endinterface

// ==== rtl/imc_sync2.sv ====
// Two-flop synchroniser for pin inputs, one stage pair per bit.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ns
module imc_sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // --------------------------------------------------------------
  // Per-bit double flop
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic stab_q;
      // First stage feeds only the second
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end else begin
          meta_q <= async_i[g];
          stab_q <= meta_q;
        end
      end
      assign sync_o[g] = stab_q;
    end
  endgenerate

endmodule // imc_sync2

// ==== rtl/imc_scl_gen.sv ====
// Quarter-period tick generator for SCL.
// Assumes the engine holds run low while the bus is idle.
`timescale 1ns/1ns
`include "imc_regs.svh"
module imc_scl_gen (
  input wire logic core_clk,
  input wire logic rst,
  imc_tick_if.gen tk
);

  localparam logic [7:0] Q00 = 8'(`IMC_SCL_DIV_00 / `IMC_SCL_PHASES);
  localparam logic [7:0] Q01 = 8'(`IMC_SCL_DIV_01 / `IMC_SCL_PHASES);
  localparam logic [7:0] Q10 = 8'(`IMC_SCL_DIV_10 / `IMC_SCL_PHASES);
  localparam logic [7:0] Q11 = 8'(`IMC_SCL_DIV_11 / `IMC_SCL_PHASES);

  logic [7:0] cnt_q;
  logic [7:0] lim;

  // Cycles per quarter SCL period
  always_comb begin
    case (tk.sel)
      2'h0: lim = Q00;
      2'h1: lim = Q01;
      2'h2: lim = Q10;
      default: lim = Q11;
    endcase
  end

  assign tk.tick = tk.run && (cnt_q == lim - 8'h01);

  // Phase counter, held at zero when idle
  always_ff @(posedge core_clk) begin
    if (rst || !tk.run || tk.tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  tick_slow_a: assert property (@(posedge core_clk) disable iff (rst)
    tk.tick && tk.sel == 2'h3 && lim == Q11 |=> !tk.tick [*8])
    else $error("tick too soon at slowest divider");

endmodule // imc_scl_gen

// ==== rtl/imc_top.sv ====
// Byte-oriented I2C master with an AHB-Lite register slave.
// Assumes one AHB master issuing single word transfers, and an
// open-drain SCL/SDA bus whose wire level is resolved outside.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
`include "imc_regs.svh"
module imc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [31:0] A_CTRL = {22'h0, `IMC_CTRL_IDX, 2'h0};
  localparam logic [31:0] A_DATA = {22'h0, `IMC_DATA_IDX, 2'h0};
  localparam logic [31:0] A_ISTAT = {22'h0, `IMC_ISTAT_IDX, 2'h0};
  localparam logic [31:0] A_IMASK = {22'h0, `IMC_IMASK_IDX, 2'h0};
  localparam logic [7:0] CTRL_RST = `IMC_CTRL_RST;

  imc_pkg::imc_state_t st_q;
  logic [1:0] ph_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic rx_q;
  logic dir_q;
  logic scl_low_q;
  logic sda_low_q;

  logic en_q;
  logic acko_q;
  logic done_q;
  logic acki_q;
  logic start_q;
  logic stop_q;
  logic [1:0] div_q;
  logic [7:0] data_q;
  logic istat_q;
  logic imask_q;
  logic irq_q;

  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] rd_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;

  logic take;
  logic ctrl_wr;
  logic data_wr;
  logic istat_wr;
  logic imask_wr;
  logic data_rd;
  logic byte_end;
  logic sda_s;

  imc_tick_if tk ();

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Pin input resynchronisation
  imc_sync2 #(.W(1)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_i(sda_i),
    .sync_o(sda_s)
  );

  // SCL quarter-period ticks
  imc_scl_gen u_gen (
    .core_clk(core_clk),
    .rst(rst),
    .tk(tk.gen)
  );

  assign tk.sel = div_q;
  assign tk.run = (st_q != imc_pkg::st_idle);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Reads take one wait state so hrdata comes from a flop
  assign take = hsel && hready && htrans[1];
  assign hreadyout = !rd_pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      rd_addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      if (take) begin
        wr_addr_q <= haddr;
        rd_addr_q <= haddr;
      end
    end
  end

  // Data phase strobes
  assign ctrl_wr = wr_pend_q && (wr_addr_q == A_CTRL);
  assign data_wr = wr_pend_q && (wr_addr_q == A_DATA);
  assign istat_wr = wr_pend_q && (wr_addr_q == A_ISTAT);
  assign imask_wr = wr_pend_q && (wr_addr_q == A_IMASK);
  assign data_rd = rd_pend_q && (rd_addr_q == A_DATA);

  // Read decode, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rd_addr_q == A_CTRL) begin
      rd_mux[7:0] = {en_q, acko_q, done_q, acki_q,
                     start_q, stop_q, div_q};
    end else if (rd_addr_q == A_DATA) begin
      rd_mux[7:0] = data_q;
    end else if (rd_addr_q == A_ISTAT) begin
      rd_mux[`IMC_F_IRQ] = istat_q;
    end else if (rd_addr_q == A_IMASK) begin
      rd_mux[`IMC_F_IRQ] = imask_q;
    end
  end

  // Read data register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  // Software-owned control fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_q <= CTRL_RST[`IMC_F_EN];
      acko_q <= CTRL_RST[`IMC_F_ACKO];
      start_q <= CTRL_RST[`IMC_F_START];
      stop_q <= CTRL_RST[`IMC_F_STOP];
      div_q <= CTRL_RST[`IMC_F_DIV_HI:`IMC_F_DIV_LO];
    end else if (ctrl_wr) begin
      en_q <= hwdata[`IMC_F_EN];
      acko_q <= hwdata[`IMC_F_ACKO];
      start_q <= hwdata[`IMC_F_START];
      stop_q <= hwdata[`IMC_F_STOP];
      div_q <= hwdata[`IMC_F_DIV_HI:`IMC_F_DIV_LO];
    end
  end

  // Byte done flag, set wins over a clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (byte_end) begin
      done_q <= 1'b1;
    end else if (ctrl_wr && !hwdata[`IMC_F_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Shift data register: software byte or received byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_q <= `IMC_DATA_RST;
    end else if (data_wr) begin
      data_q <= hwdata[7:0];
    end else if (byte_end && rx_q) begin
      data_q <= sh_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  // Sticky status, write one to clear, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      istat_q <= 1'b0;
      imask_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (byte_end) begin
        istat_q <= 1'b1;
      end else if (istat_wr && hwdata[`IMC_F_IRQ]) begin
        istat_q <= 1'b0;
      end
      if (imask_wr) begin
        imask_q <= hwdata[`IMC_F_IRQ];
      end
      irq_q <= istat_q && imask_q;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  assign byte_end = en_q && (st_q == imc_pkg::st_ack) && tk.tick &&
                    (ph_q == 2'h3);

  // Open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;

  // Sequencer over START, bits, ack, wait and STOP
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= imc_pkg::st_idle;
      ph_q <= 2'h0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rx_q <= 1'b0;
      dir_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      acki_q <= 1'b0;
    end else if (!en_q) begin
      st_q <= imc_pkg::st_idle;
      ph_q <= 2'h0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      case (st_q)
        imc_pkg::st_idle: begin
          ph_q <= 2'h0;
          scl_low_q <= 1'b0;
          sda_low_q <= 1'b0;
          if (start_q && !stop_q) begin
            st_q <= imc_pkg::st_start;
          end
        end
        imc_pkg::st_start: begin
          if (tk.tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h1) begin
              sda_low_q <= 1'b1;
            end else if (ph_q == 2'h2) begin
              scl_low_q <= 1'b1;
            end else if (ph_q == 2'h3) begin
              st_q <= imc_pkg::st_bit;
              sh_q <= data_q;
              dir_q <= data_q[0];
              rx_q <= 1'b0;
              cnt_q <= `IMC_BIT_LAST;
            end
          end
        end
        imc_pkg::st_bit: begin
          if (tk.tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              sda_low_q <= !rx_q && !sh_q[7];
            end else if (ph_q == 2'h1) begin
              scl_low_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              if (rx_q) begin
                sh_q <= {sh_q[6:0], sda_s};
              end
            end else begin
              scl_low_q <= 1'b1;
              if (!rx_q) begin
                sh_q <= {sh_q[6:0], 1'b0};
              end
              if (cnt_q == 3'h0) begin
                st_q <= imc_pkg::st_ack;
              end else begin
                cnt_q <= cnt_q - 3'h1;
              end
            end
          end
        end
        imc_pkg::st_ack: begin
          if (tk.tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              sda_low_q <= rx_q && !acko_q;
            end else if (ph_q == 2'h1) begin
              scl_low_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              if (!rx_q) begin
                acki_q <= sda_s;
              end
            end else begin
              scl_low_q <= 1'b1;
              st_q <= imc_pkg::st_wait;
            end
          end
        end
        imc_pkg::st_wait: begin
          ph_q <= 2'h0;
          sda_low_q <= 1'b0;
          cnt_q <= `IMC_BIT_LAST;
          if (stop_q && !start_q) begin
            st_q <= imc_pkg::st_stop;
          end else if (start_q && data_wr && !dir_q) begin
            st_q <= imc_pkg::st_bit;
            sh_q <= hwdata[7:0];
            rx_q <= 1'b0;
          end else if (start_q && data_rd && dir_q) begin
            st_q <= imc_pkg::st_bit;
            rx_q <= 1'b1;
          end
        end
        imc_pkg::st_stop: begin
          if (tk.tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              sda_low_q <= 1'b1;
            end else if (ph_q == 2'h1) begin
              scl_low_q <= 1'b0;
            end else if (ph_q == 2'h2) begin
              sda_low_q <= 1'b0;
            end else begin
              st_q <= imc_pkg::st_idle;
            end
          end
        end
        default: begin
          st_q <= imc_pkg::st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  start_launch_a: assert property (
    st_q == imc_pkg::st_idle && en_q && start_q && !stop_q
    |=> st_q == imc_pkg::st_start)
    else $error("start request did not begin START");

  done_set_a: assert property (byte_end |=> done_q && istat_q)
    else $error("byte end did not set done flags");

  done_clear_a: assert property (
    ctrl_wr && !hwdata[`IMC_F_DONE] && !byte_end |=> !done_q)
    else $error("writing zero did not clear done flag");

  tx_launch_a: assert property (
    en_q && st_q == imc_pkg::st_wait && start_q && data_wr && !dir_q
    |=> st_q == imc_pkg::st_bit && !rx_q && sh_q == $past(hwdata[7:0]))
    else $error("data write did not launch transmit");

  rx_launch_a: assert property (
    en_q && st_q == imc_pkg::st_wait && start_q && data_rd && dir_q
    |=> st_q == imc_pkg::st_bit && rx_q)
    else $error("data read did not launch receive");

  rx_store_a: assert property (
    byte_end && rx_q |=> data_q == $past(sh_q))
    else $error("received byte not stored");

  stop_go_a: assert property (
    en_q && st_q == imc_pkg::st_wait && stop_q && !start_q
    |=> st_q == imc_pkg::st_stop ##[1:70] sda_oe)
    else $error("stop request did not begin STOP");

  irq_gate_a: assert property (
    !(istat_q && imask_q) |=> !irq)
    else $error("interrupt raised while gated");

  ack_drive_a: assert property (
    en_q && st_q == imc_pkg::st_ack && rx_q && ph_q == 2'h2
    |-> sda_oe == !acko_q)
    else $error("receive ack level wrong");

  idle_quiet_a: assert property (
    !en_q |=> st_q == imc_pkg::st_idle && !scl_oe && !sda_oe)
    else $error("bus active while disabled");

  tx_byte_c: cover property (byte_end && !rx_q && dir_q == 1'b0);
  rx_byte_c: cover property (byte_end && rx_q);
  stop_done_c: cover property (
    st_q == imc_pkg::st_stop ##1 st_q == imc_pkg::st_idle);

endmodule // imc_top

// ==== bench/imc_slave_model.sv ====
// Behavioural I2C slave: acks written bytes, returns two bytes on reads.
// Assumes resolved open-drain wire levels with pull-ups on both lines.
`timescale 1ns/1ns
module imc_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_data,
  input wire logic [7:0] tx_a,
  input wire logic [7:0] tx_b,
  output logic sda_pull,
  output logic [15:0] rx_log,
  output logic [1:0] mack_log
);
  logic [7:0] sh;
  logic [7:0] txb;
  logic rd;
  logic first;
  int k;

  // Frame follower: START opens, STOP aborts whatever is in flight
  initial begin
    sda_pull = 1'b0;
    rx_log = 16'h0000;
    mack_log = 2'h0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      fork
        begin
          rd = 1'b0;
          first = 1'b1;
          k = 0;
          txb = 8'h00;
          @(negedge scl);
          forever begin
            for (int i = 7; i >= 0; i--) begin
              @(posedge scl);
              sh[i] = sda;
              @(negedge scl);
              if (i > 0) sda_pull = rd & ~txb[i-1];
            end
            if (!rd) rx_log = {rx_log[7:0], sh};
            // Address always acked, data acked unless told otherwise
            sda_pull = !rd && !(nack_data && !first);
            @(posedge scl);
            if (rd) mack_log = {mack_log[0], sda};
            if (rd && sda) rd = 1'b0;
            @(negedge scl);
            if (first) rd = sh[0];
            first = 1'b0;
            if (rd) txb = (k == 0) ? tx_a : tx_b;
            if (rd) k++;
            sda_pull = rd & ~txb[7];
          end
        end
        @(posedge sda iff scl === 1'b1);
      join_any
      disable fork;
      sda_pull = 1'b0;
    end
  end
endmodule // imc_slave_model

// ==== bench/i2c_master_byte_controller_bench.sv ====
// Self-checking bench: register bus, frames, divider, irq, enable.
// Assumes imc_top with hready looped back and a slave model on the wires.
`timescale 1ns/1ns
`include "imc_regs.svh"
module i2c_master_byte_controller_bench;
  typedef struct packed {
    logic [1:0] div;
    logic [7:0] adr;
    logic [15:0] per;
  } imc_row_t;
  localparam logic [31:0] C_EN = 32'h80;
  localparam logic [31:0] C_ACKO = 32'h40;
  localparam logic [31:0] C_START = 32'h08;
  localparam logic [31:0] C_STOP = 32'h04;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, scl_o, scl_oe, sda_o, sda_oe;
  logic [31:0] hrdata;
  logic [31:0] rd_q;
  logic scl_w, sda_w, sda_pull;
  logic nack_data = 1'b0;
  logic scl_prev = 1'b1;
  logic [15:0] rx_log;
  logic [1:0] mack_log;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int rise_last = 0;
  int rise_prev = 0;
  imc_row_t rows [4] = '{'{2'h0, 8'hA0, 16'h4}, '{2'h1, 8'h5A, 16'h10},
    '{2'h2, 8'h3C, 16'h40}, '{2'h3, 8'hC2, 16'h100}};

  // Open-drain wires with pull-ups
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || sda_pull);

  // Clock
  always #5 core_clk = ~core_clk;

  // Cycle stamps of the last two SCL rises
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    scl_prev <= scl_w;
    if (scl_w && !scl_prev) begin
      rise_prev <= rise_last;
      rise_last <= cyc;
    end
  end

  imc_top imc_top_inst (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );

  imc_slave_model imc_slave_model_inst (
    .scl(scl_w), .sda(sda_w), .nack_data(nack_data), .tx_a(8'h25),
    .tx_b(8'hA6), .sda_pull(sda_pull), .rx_log(rx_log),
    .mack_log(mack_log)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One AHB single transfer; read data lands in rd_q
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge core_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    rd_q = hrdata;
    if (n >= 50) check(32'(n), 32'h0);
  endtask

  // Poll the control register until the byte done flag shows
  task automatic wait_done;
    int n;
    n = 0;
    rd_q = 32'h0;
    while (rd_q[`IMC_F_DONE] !== 1'b1 && n < 2000) begin
      bus(1'b0, `IMC_CTRL_IDX, 32'h0);
      n++;
    end
    if (n >= 2000) check(32'(n), 32'h0);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    #600000;
    err_count++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    // Reset values, response code and an unmapped place
    check({31'h0, hresp}, 32'h0);
    check({28'h0, hreadyout, irq, scl_oe, sda_oe}, 32'h8);
    check({30'h0, scl_o, sda_o}, 32'h0);
    check(hrdata, 32'h0);
    bus(1'b0, `IMC_CTRL_IDX, 32'h0);
    check(rd_q, {24'h0, `IMC_CTRL_RST});
    bus(1'b0, `IMC_DATA_IDX, 32'h0);
    check(rd_q, {24'h0, `IMC_DATA_RST});
    bus(1'b0, `IMC_ISTAT_IDX, 32'h0);
    check(rd_q, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check(rd_q, 32'h0);
    // Address-only frames at every divider setting
    foreach (rows[r]) begin
      bus(1'b1, `IMC_DATA_IDX, {24'h0, rows[r].adr});
      bus(1'b1, `IMC_CTRL_IDX, C_EN | C_START | rows[r].div);
      wait_done;
      check(rd_q & 32'h30, 32'h20);
      check(32'(rise_last - rise_prev), {16'h0, rows[r].per});
      check({24'h0, rx_log[7:0]}, {24'h0, rows[r].adr});
      check({31'h0, irq}, 32'h0);
      bus(1'b1, `IMC_CTRL_IDX, C_EN | C_STOP | rows[r].div);
      bus(1'b0, `IMC_CTRL_IDX, 32'h0);
      check(rd_q & 32'h20, 32'h0);
      idle(2 * rows[r].per + 8);
      check({30'h0, scl_oe, sda_oe}, 32'h0);
    end
    // Transmit with a refusing slave, interrupt masking and clearing
    nack_data <= 1'b1;
    bus(1'b1, `IMC_IMASK_IDX, 32'h1);
    bus(1'b1, `IMC_DATA_IDX, 32'h50);
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_START | 32'h1);
    wait_done;
    idle(2);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, `IMC_IMASK_IDX, 32'h0);
    idle(2);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `IMC_IMASK_IDX, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, `IMC_ISTAT_IDX, 32'h1);
    idle(2);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, `IMC_ISTAT_IDX, 32'h0);
    check(rd_q, 32'h0);
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_START | 32'h1);
    bus(1'b1, `IMC_DATA_IDX, 32'h96);
    wait_done;
    check(rd_q & 32'h10, 32'h10);
    check({24'h0, rx_log[7:0]}, 32'h96);
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_STOP | 32'h1);
    idle(40);
    // Receive two bytes, acking the first and refusing the last
    nack_data <= 1'b0;
    bus(1'b1, `IMC_DATA_IDX, 32'hA1);
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_START | 32'h1);
    wait_done;
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_START | 32'h1);
    bus(1'b0, `IMC_DATA_IDX, 32'h0);
    check(rd_q, 32'hA1);
    wait_done;
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_ACKO | C_START | 32'h1);
    bus(1'b0, `IMC_DATA_IDX, 32'h0);
    check(rd_q, 32'h25);
    wait_done;
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_STOP | 32'h1);
    bus(1'b0, `IMC_DATA_IDX, 32'h0);
    check(rd_q, 32'hA6);
    check({30'h0, mack_log}, 32'h1);
    idle(40);
    // Start request with the master disabled moves no line
    bus(1'b1, `IMC_CTRL_IDX, C_START | 32'h1);
    n = 0;
    repeat (100) begin
      @(posedge core_clk);
      if (scl_oe !== 1'b0 || sda_oe !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
    // Reset in mid-frame drops both lines and restores the registers
    bus(1'b1, `IMC_CTRL_IDX, C_STOP);
    idle(300);
    bus(1'b1, `IMC_DATA_IDX, 32'hA0);
    bus(1'b1, `IMC_CTRL_IDX, C_EN | C_START | 32'h3);
    idle(600);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    @(posedge core_clk);
    check({28'h0, hreadyout, irq, scl_oe, sda_oe}, 32'h8);
    bus(1'b0, `IMC_CTRL_IDX, 32'h0);
    check(rd_q, {24'h0, `IMC_CTRL_RST});
    bus(1'b0, `IMC_DATA_IDX, 32'h0);
    check(rd_q, {24'h0, `IMC_DATA_RST});
    print_verdict;
  end
endmodule // i2c_master_byte_controller_bench
